// file: logic/sar_host.sv
/*
  Host controller that drives the converter's select, read, start and
  byte pins, waits on busy, reads the result and queues it in a FIFO.
  Assumes the converter pins are asynchronous to CLK; busy and the data
  bus are synchronised here. Only one clock.
  The result FIFO module sits at the end of this file.
*/
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - Start falling edge ends acquisition and begins the conversion.
// - Select falling edge begins the acquisition period.
// - Second start or select fall 70..500 ns after start aborts it.
// - Host reads only after max conversion time plus 20 ns.
// - Host keeps select rises 50 ns from the busy falling edge.
// - Host spaces byte-select transitions at least 50 ns apart.
// - Reset low aborts conversion and clears output latches.
// - Select and read strobe low enable the previous result onto bus.
module sar_host #(
  parameter int DEPTH = 16,
  parameter bit BYTE_MODE = 1'b0
) (
  // Clock and reset
  input  wire logic                          CLK,
  input  wire logic                          RST,
  // User control
  input  wire logic                          START,
  input  wire logic                          ABORT,
  output logic                               ACTIVE,
  // Result stream
  output logic                               RES_VALID,
  input  wire logic                          RES_READY,
  output logic      [sar_pkg::DATA_W-1:0]    RES_DATA,
  // Converter pins
  output sar_pkg::sar_pins_t                 PINS,
  input  wire logic                          BUSY,
  input  wire logic [sar_pkg::DATA_W-1:0]    BUS_IN
);
  sar_pkg::sar_state_t state;
  logic [sar_pkg::CNT_W-1:0] cnt;
  logic [2:0]  busy_sync;
  logic [sar_pkg::DATA_W-1:0] bus_s1;
  logic [sar_pkg::DATA_W-1:0] bus_s2;
  logic [sar_pkg::DATA_W-1:0] bus_s3;
  logic [sar_pkg::DATA_W-1:0] bus_now;
  logic        busy_now;
  logic        busy_seen;
  logic        busy_fell;
  logic        second_byte;
  logic [sar_pkg::DATA_W-1:0] captured;
  logic        abort_now;
  logic        fifo_ready;
  logic        push;
  logic [sar_pkg::DATA_W-1:0] push_data;
  logic        reset_pulse;

  function automatic logic [sar_pkg::CNT_W-1:0] cyc(input int n);
    return sar_pkg::CNT_W'(n);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Busy is from the pin: change counts once stages two and three agree
  always_ff @(posedge CLK) begin
    if (RST) begin
      busy_sync <= 3'h0;
      busy_now  <= 1'b0;
    end else begin
      busy_sync <= {busy_sync[1:0], BUSY};
      if (busy_sync[1] == busy_sync[2]) begin
        busy_now <= busy_sync[2];
      end
    end
  end
  assign busy_fell = busy_now && (busy_sync[1] == busy_sync[2]) && !busy_sync[2];
  assign abort_now = state == sar_pkg::S_WAIT && ABORT && !busy_seen && !busy_fell;

  // Data bus from the pins: a value counts once stages two and three agree.
  // The strobe is held far longer than this lag, so the word is settled
  // well before the sequencer takes it.
  always_ff @(posedge CLK) begin
    if (RST) begin
      bus_s1  <= sar_pkg::RESULT_RST;
      bus_s2  <= sar_pkg::RESULT_RST;
      bus_s3  <= sar_pkg::RESULT_RST;
      bus_now <= sar_pkg::RESULT_RST;
    end else begin
      bus_s1 <= BUS_IN;
      bus_s2 <= bus_s1;
      bus_s3 <= bus_s2;
      if (bus_s2 == bus_s3) begin
        bus_now <= bus_s3;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge CLK) begin
    if (RST) begin
      state       <= sar_pkg::S_IDLE;
      cnt         <= '0;
      busy_seen   <= 1'b0;
      second_byte <= 1'b0;
      reset_pulse <= 1'b1;
    end else begin
      reset_pulse <= 1'b0;
      cnt <= (cnt == '0) ? '0 : cnt - 1'b1;
      unique case (state)
        sar_pkg::S_IDLE: begin
          // New conversion only from idle, so busy has already fallen
          if (START && !reset_pulse) begin
            state <= sar_pkg::S_SELECT;
          end
        end
        sar_pkg::S_SELECT: begin
          state <= sar_pkg::S_ACQ;
          cnt   <= cyc(sar_pkg::CYC_ACQ);
        end
        sar_pkg::S_ACQ: begin
          if (cnt == '0) begin
            state <= sar_pkg::S_CVLOW;
            cnt   <= cyc(sar_pkg::CYC_CVLOW);
          end
        end
        sar_pkg::S_CVLOW: begin
          if (cnt == '0) begin
            state     <= sar_pkg::S_WAIT;
            busy_seen <= 1'b0;
            cnt       <= cyc(sar_pkg::CYC_CONV_WAIT);
          end
        end
        sar_pkg::S_WAIT: begin
          if (busy_fell) begin
            busy_seen <= 1'b1;
          end
          if (abort_now) begin
            // Abort by reset pulse; avoids timing a 70..500 ns window.
            // Once busy has fallen the result is read instead, so select
            // never rises right on the heels of the busy edge.
            state       <= sar_pkg::S_DESEL;
            reset_pulse <= 1'b1;
            cnt         <= cyc(sar_pkg::CYC_CSBUSY);
          end else if (cnt == '0 && (busy_seen || busy_fell)) begin
            state <= sar_pkg::S_GUARD;
            cnt   <= cyc(sar_pkg::CYC_CSBUSY);
          end
        end
        sar_pkg::S_GUARD: begin
          if (cnt == '0) begin
            state       <= sar_pkg::S_RD;
            second_byte <= 1'b0;
            cnt         <= cyc(sar_pkg::CYC_RDLOW);
          end
        end
        sar_pkg::S_RD: begin
          if (cnt == '0) begin
            if (BYTE_MODE && !second_byte) begin
              state <= sar_pkg::S_BYTE;
              cnt   <= cyc(sar_pkg::CYC_BYTE);
            end else begin
              state <= sar_pkg::S_RDHI;
              cnt   <= cyc(sar_pkg::CYC_RDCONV);
            end
          end
        end
        sar_pkg::S_BYTE: begin
          // Strobe high while byte select flips, then hold off
          if (cnt == '0) begin
            state       <= sar_pkg::S_RD;
            second_byte <= 1'b1;
            cnt         <= cyc(sar_pkg::CYC_RDLOW);
          end
        end
        sar_pkg::S_RDHI: begin
          // Select stays low until fifo can take the word
          if (cnt == '0 && fifo_ready) begin
            state <= sar_pkg::S_DESEL;
            cnt   <= cyc(sar_pkg::CYC_RDCONV);
          end
        end
        sar_pkg::S_DESEL: begin
          if (cnt == '0) begin
            state <= sar_pkg::S_IDLE;
          end
        end
        default: begin
          state <= sar_pkg::S_IDLE;
        end
      endcase
    end
  end

  // The word is taken at the end of each strobe, while the bus is still
  // driven; once the strobe rises the lines float and must not be read.
  always_ff @(posedge CLK) begin
    if (RST) begin
      captured <= sar_pkg::RESULT_RST;
    end else if (state == sar_pkg::S_RD && cnt == '0) begin
      if (BYTE_MODE && second_byte) begin
        // Lower lines read as ones in byte mode and are discarded
        captured[7:0] <= bus_now[15:8];
      end else begin
        captured <= bus_now;
      end
    end
  end

  assign push      = state == sar_pkg::S_RDHI && cnt == '0 && fifo_ready;
  assign push_data = captured;

  //////////////////////////////////////////////////////////////////////////////
  // Pins driven from flops
  always_ff @(posedge CLK) begin
    if (RST) begin
      PINS <= '{cs_n: 1'b1, rd_n: 1'b1, conversion_start_n: 1'b1,
                byte_sel: 1'b0, reset_n: 1'b0};
    end else begin
      PINS.reset_n  <= !(reset_pulse || abort_now);
      PINS.cs_n     <= state inside {sar_pkg::S_IDLE, sar_pkg::S_DESEL};
      PINS.conversion_start_n <= state != sar_pkg::S_CVLOW;
      PINS.rd_n     <= state != sar_pkg::S_RD;
      PINS.byte_sel <= BYTE_MODE && (state == sar_pkg::S_RD || state == sar_pkg::S_BYTE)
                       ? (state == sar_pkg::S_BYTE || second_byte) : 1'b0;
    end
  end

  assign ACTIVE = state != sar_pkg::S_IDLE;

  sar_fifo #(
    .WIDTH (sar_pkg::DATA_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk       (CLK),
    .rst       (RST),
    .in_valid  (push),
    .in_ready  (fifo_ready),
    .in_data   (push_data),
    .out_valid (RES_VALID),
    .out_ready (RES_READY),
    .out_data  (RES_DATA)
  );
endmodule

////////////////////////////////////////////////////////////////////////////////
// Result queue: synchronous, valid and ready on both sides
module sar_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready  = count != (AW+1)'(DEPTH);
  assign out_valid = count != '0;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// file: logic/sar_pkg.sv
/*
  Package for the host-side controller of a 16-bit sampling converter.
  Assumes a 100 MHz CLK; all times are converted to cycles here.
*/
package sar_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int DATA_W        = 16;
  // Timing figures in ns as specified
  localparam int T_CONV_MAX_NS = 610;
  localparam int T_EOC_DATA_NS = 20;
  localparam int T_CSBUSY_NS   = 50;
  localparam int T_BYTE_NS     = 50;
  localparam int T_RDLOW_NS    = 50;
  localparam int T_CVLOW_NS    = 20;
  localparam int T_ACQ_NS      = 150;
  localparam int T_ENABLE_NS   = 30;
  localparam int T_RDCONV_NS   = 50;
  // Least times round up
  localparam int CYC_CONV_WAIT = (T_CONV_MAX_NS + T_EOC_DATA_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam int CYC_CSBUSY    = (T_CSBUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_BYTE      = (T_BYTE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_RDLOW     = (T_RDLOW_NS + T_ENABLE_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam int CYC_CVLOW     = (T_CVLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_ACQ       = (T_ACQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_RDCONV    = (T_RDCONV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W         = 8;
  localparam logic [DATA_W-1:0] RESULT_RST = 16'h0000;

  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic conversion_start_n;
    logic byte_sel;
    logic reset_n;
  } sar_pins_t;

  typedef enum logic [9:0] {
    S_IDLE   = 10'h001,
    S_SELECT = 10'h002,
    S_ACQ    = 10'h004,
    S_CVLOW  = 10'h008,
    S_WAIT   = 10'h010,
    S_GUARD  = 10'h020,
    S_RD     = 10'h040,
    S_RDHI   = 10'h080,
    S_BYTE   = 10'h100,
    S_DESEL  = 10'h200
  } sar_state_t;
endpackage

// file: logic/sar_fifo.sv
/*
  Holds no code: the result FIFO is declared beside the host controller,
  so that one file carries all of the block's logic.
  Assumes nothing of its surroundings.
*/

// file: tb/sar_host_sva.sv
/*
  Checker for the converter host: pin order against busy and reset.
  Assumes it is bound onto sar_host and sees only its ports.
*/
`timescale 1ns/1ns
module sar_host_sva (
  // Clock and reset
  input wire logic               CLK,
  input wire logic               RST,
  // Stream and converter pins
  input wire logic               RES_VALID,
  input wire logic               RES_READY,
  input wire sar_pkg::sar_pins_t PINS,
  input wire logic               BUSY
);
  int since_cv;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  // Saturates so a long idle spell never wraps back below the limit
  always_ff @(posedge CLK) begin
    if (RST) begin
      since_cv <= 0;
    end else if ($fell(PINS.conversion_start_n)) begin
      since_cv <= 1;
    end else if (since_cv < 1000) begin
      since_cv <= since_cv + 1;
    end
  end
  ////////////////////////////////////////
  a_reset_pins_idle: assert property (
    $fell(RST) |-> PINS.cs_n && PINS.rd_n && PINS.conversion_start_n && !PINS.reset_n)
    else $error("pins not idle after reset");
  a_start_when_sel: assert property (
    $fell(PINS.conversion_start_n) |-> !PINS.cs_n) else $error("start without select");
  a_acq_before_start: assert property (
    $fell(PINS.conversion_start_n) |-> $past(PINS.cs_n, 14) == 1'b0)
    else $error("acquisition too short");
  a_read_after_conv: assert property (
    $fell(PINS.rd_n) |-> since_cv >= sar_pkg::CYC_CONV_WAIT) else $error("read too early");
  a_sel_busy_guard: assert property (
    $fell(BUSY) && PINS.reset_n |-> $stable(PINS.cs_n) [*5]) else $error("select near busy");
  a_byte_spacing: assert property (
    $changed(PINS.byte_sel) |=> $stable(PINS.byte_sel) [*4]) else $error("byte too fast");
  a_byte_hold_rd: assert property (
    !PINS.rd_n && $past(PINS.rd_n) == 1'b0 |-> $stable(PINS.byte_sel))
    else $error("byte moved in read");
  a_read_when_sel: assert property (
    !PINS.rd_n |-> !PINS.cs_n) else $error("read without select");
  a_start_not_busy: assert property (
    $fell(PINS.conversion_start_n) |-> !BUSY) else $error("start while busy");
  c_read: cover property ($fell(PINS.rd_n));
  c_byte: cover property ($rose(PINS.byte_sel));
  c_abort: cover property ($fell(PINS.reset_n));
  c_pop: cover property (RES_VALID && RES_READY);
endmodule

bind sar_host sar_host_sva sar_host_sva_i (.CLK(CLK), .RST(RST), .RES_VALID(RES_VALID),
  .RES_READY(RES_READY), .PINS(PINS), .BUSY(BUSY));

// file: tb/sar_conv_model.sv
/*
  Behavioural model of the converter: busy, result latch and data bus.
  Assumes one host drives its pins; it has no clock of its own.
*/
`timescale 1ns/1ns
module sar_conv_model #(
  parameter logic [15:0] FIRST = 16'h0000,
  parameter logic [15:0] STEP  = 16'h0001
) (
  // Host pins and the slow-conversion switch
  input  wire sar_pkg::sar_pins_t pins,
  input  wire logic               slow,
  // Converter outputs
  output logic                    busy,
  output logic             [15:0] bus
);
  logic [15:0] result;
  logic [15:0] sample;
  logic [15:0] drv;
  int          gen;

  initial begin
    busy = 1'b0;
    result = 16'h0000;
    sample = FIRST;
    gen = 0;
  end
  ////////////////////////////////////////
  // A stale generation means the conversion was aborted meanwhile
  task automatic run(int g);
    #20;
    if (g == gen) busy = 1'b1;
    #(slow ? 900 : 580);
    if (g == gen) begin
      result = sample;
      sample = sample + STEP;
      busy = 1'b0;
    end
  endtask
  always @(negedge pins.conversion_start_n) begin
    if (!pins.cs_n && pins.reset_n) begin
      gen++;
      fork
        run(gen);
      join_none
    end
  end
  always @(negedge pins.reset_n) begin
    gen++;
    busy = 1'b0;
    result = 16'h0000;
  end
  assign drv = pins.byte_sel ? {result[7:0], 8'hff} : result;
  // Released bus shows the inverse so a late sample cannot match by luck
  assign bus = (!pins.cs_n && !pins.rd_n) ? drv : ~drv;
endmodule

// file: tb/test_sar_adc_parallel_readout.sv
/*
  Testbench for the converter host: a word host and a byte host,
  each facing its own converter model.
  Assumes package, FIFO, host, model and checker are compiled first.
*/
`timescale 1ns/1ns
module test_sar_adc_parallel_readout;
  localparam logic [15:0] FIRST = 16'ha5c3;
  localparam logic [15:0] STEP  = 16'h1111;
  logic               CLK;
  logic               RST;
  logic               slow;
  logic               start [2];
  logic               abort [2];
  logic               active [2];
  logic               res_valid [2];
  logic               res_ready [2];
  logic        [15:0] res_data [2];
  sar_pkg::sar_pins_t pins [2];
  logic               busy [2];
  logic        [15:0] bus [2];
  logic        [15:0] exp_w [2];
  int                 fails;
  int                 num_checks;

  always #5 CLK = ~CLK;

  for (genvar m = 0; m < 2; m++) begin : g_mode
    sar_host #(.DEPTH(16), .BYTE_MODE(m == 1)) sar_host_i (.CLK(CLK), .RST(RST),
      .START(start[m]), .ABORT(abort[m]), .ACTIVE(active[m]), .RES_VALID(res_valid[m]),
      .RES_READY(res_ready[m]), .RES_DATA(res_data[m]), .PINS(pins[m]), .BUSY(busy[m]),
      .BUS_IN(bus[m]));
    sar_conv_model #(.FIRST(FIRST), .STEP(STEP)) sar_conv_model_i (.pins(pins[m]),
      .slow(slow), .busy(busy[m]), .bus(bus[m]));
  end
  ////////////////////////////////////////
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic pop(int m);
    @(negedge CLK) res_ready[m] = 1'b1;
    @(negedge CLK) res_ready[m] = 1'b0;
  endtask
  // One conversion; keep leaves the word queued
  task automatic conv(int m, bit keep);
    int n;
    @(negedge CLK) start[m] = 1'b1;
    @(negedge CLK) start[m] = 1'b0;
    n = 0;
    while (active[m] === 1'b1 && n < 400) begin
      @(negedge CLK);
      n++;
    end
    check("valid", {15'h0, res_valid[m]}, 16'h0001);
    if (!keep) begin
      check("word", res_data[m], exp_w[m]);
      pop(m);
    end
    exp_w[m] = exp_w[m] + STEP;
  endtask
  task automatic t_idle();
    check("idle pins", {11'h0, pins[0]}, 16'h001d);
  endtask
  task automatic t_words();
    for (int m = 0; m < 2; m++) begin
      conv(m, 1'b0);
      conv(m, 1'b0);
    end
  endtask
  task automatic t_abort(int m);
    int n;
    @(negedge CLK) start[m] = 1'b1;
    @(negedge CLK) start[m] = 1'b0;
    n = 0;
    while (busy[m] !== 1'b1 && n < 100) begin
      @(negedge CLK);
      n++;
    end
    repeat (10) @(negedge CLK);
    abort[m] = 1'b1;
    n = 0;
    while (active[m] === 1'b1 && n < 100) begin
      @(negedge CLK);
      n++;
    end
    abort[m] = 1'b0;
    check("abort", {13'h0, busy[m], res_valid[m], active[m]}, 16'h0000);
    conv(m, 1'b0);
  endtask
  task automatic t_slow();
    slow = 1'b1;
    conv(1, 1'b0);
    conv(0, 1'b0);
    slow = 1'b0;
  endtask
  // Consumer stalls while sixteen words queue up, then drains them all
  task automatic t_fill();
    logic [15:0] e;
    e = exp_w[0];
    for (int i = 0; i < 16; i++) conv(0, 1'b1);
    for (int i = 0; i < 16; i++) begin
      check("queued", res_data[0], e);
      pop(0);
      e = e + STEP;
    end
    check("empty", {15'h0, res_valid[0]}, 16'h0000);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    CLK = 1'b0;
    RST = 1'b1;
    slow = 1'b0;
    start = '{1'b0, 1'b0};
    abort = '{1'b0, 1'b0};
    res_ready = '{1'b0, 1'b0};
    exp_w = '{FIRST, FIRST};
    fails = 0;
    num_checks = 0;
    repeat (4) @(negedge CLK);
    RST = 1'b0;
    repeat (3) @(negedge CLK);
    t_idle();
    t_words();
    t_abort(0);
    t_slow();
    t_fill();
    test_done();
  end
  initial begin
    #300000;
    fails++;
    test_done();
  end
endmodule
